// >>> hdl/ppio_ports.sv
// Parallel I/O port logic: nine ports, data, direction, open drain, threshold.
// Assumes a CPU register port with one-cycle strobes; pins are asynchronous.
//
// The strobed register port is this design's own decision.
`timescale 1ns/100ps
module ppio_ports
    import ppio_pkg::*;
#(
    parameter int NPORT = `PPIO_NPORT
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [`PPIO_ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [1:0] reg_op,
    output logic [15:0] reg_rdata,
    input wire logic [NPORT*16-1:0] pin_in,
    output logic [NPORT*16-1:0] pin_out,
    output logic [NPORT*16-1:0] pin_oe,
    output logic [15:0] threshold_sel_out
);
    initial
    begin
        if (NPORT != `PPIO_NPORT)
            $error("ppio_ports supports exactly nine ports");
        if (`PPIO_ADDR_W != 16)
            $error("ppio_ports decodes sixteen address bits only");
        if ((`PPIO_DATA_OFF & 16'h001E) != 16'h0000)
            $error("data block base overlaps the port index bits");
        if ((`PPIO_DIR_OFF & 16'h001E) != 16'h0000)
            $error("direction block base overlaps the port index bits");
        if ((`PPIO_ODS_OFF & 16'h001E) != 16'h0000)
            $error("open-drain block base overlaps the port index bits");
        if (kind_match(`PPIO_THR_OFF, `PPIO_DATA_OFF)
            || kind_match(`PPIO_THR_OFF, `PPIO_DIR_OFF)
            || kind_match(`PPIO_THR_OFF, `PPIO_ODS_OFF))
            $error("threshold register falls inside a port block");
        if (`PPIO_THR_MASK != thr_field_mask())
            $error("threshold mask disagrees with its field positions");
        if ((`PPIO_THR_RST & ~`PPIO_THR_MASK) != 16'h0000)
            $error("threshold reset value sets a reserved bit");
        if (`PPIO_OP_RMW == `PPIO_OP_WR)
            $error("write and read-modify-write codes must differ");
    end

    // Implemented lines per port
    function automatic ppio_word_t line_mask(input int p);
        case (p)
            3: line_mask = 16'hBFFF;
            4, 6, 7, 8: line_mask = 16'h00FF;
            default: line_mask = 16'hFFFF;
        endcase
    endfunction

    function automatic logic has_od(input int p);
        case (p)
            2, 3, 4, 6, 7, 8: has_od = 1'b1;
            default: has_od = 1'b0;
        endcase
    endfunction

    // Data seen by software: latch where driven, pin where not
    function automatic ppio_word_t mix(input ppio_word_t d,
                                       input ppio_word_t l,
                                       input ppio_word_t p);
        mix = (d & l) | (~d & p);
    endfunction

    // Port 5 has no output latch and no direction register
    function automatic logic has_out(input int p);
        has_out = (p != 5);
    endfunction

    // Register block base match, ignoring the port index bits
    function automatic logic kind_match(input ppio_word_t a,
                                        input ppio_word_t base);
        kind_match = (a & 16'hFFE1) == base;
    endfunction

    // Writable threshold selects, built from the field positions
    function automatic ppio_word_t thr_field_mask();
        thr_field_mask = '0;
        thr_field_mask[`PPIO_P2L_BIT] = 1'b1;
        thr_field_mask[`PPIO_P2H_BIT] = 1'b1;
        thr_field_mask[`PPIO_P3L_BIT] = 1'b1;
        thr_field_mask[`PPIO_P3H_BIT] = 1'b1;
        thr_field_mask[`PPIO_P4_BIT] = 1'b1;
        thr_field_mask[`PPIO_P7_BIT] = 1'b1;
        thr_field_mask[`PPIO_P8_BIT] = 1'b1;
    endfunction

    // Software merges pin or latch view before a read-modify-write,
    // so both codes store the written word; no atomic hardware path
    function automatic ppio_word_t latch_next(input logic [1:0] op,
                                              input ppio_word_t w,
                                              input int p);
        if (op == `PPIO_OP_RMW)
            latch_next = w & line_mask(p);
        else
            latch_next = w & line_mask(p);
    endfunction

    // Register view of one port, selected by the decoded kind
    function automatic ppio_word_t port_view(input logic [1:0] kind,
                                             input ppio_word_t d,
                                             input ppio_word_t l,
                                             input ppio_word_t i,
                                             input ppio_word_t o);
        case (kind)
            2'h1: port_view = mix(d, l, i);
            2'h2: port_view = d;
            2'h3: port_view = o;
            default: port_view = '0;
        endcase
    endfunction

    logic [NPORT*16-1:0] pin_sync;
    logic [NPORT*16-1:0] pad_o;
    logic [NPORT*16-1:0] pad_e;
    ppio_word_t in_latch_q [NPORT];
    ppio_word_t out_latch_q [NPORT];
    ppio_word_t dir_q [NPORT];
    ppio_word_t od_q [NPORT];
    ppio_word_t thr_q;
    logic [NPORT*16-1:0] lat_flat;
    logic [NPORT*16-1:0] dir_flat;
    logic [NPORT*16-1:0] od_flat;
    logic [3:0] sel_port;
    logic [1:0] sel_kind;
    logic sel_hit;
    logic wr_data;
    logic wr_dir;
    logic wr_od;
    logic wr_thr;
    logic rd_thr;
    logic rd_port;
    logic [NPORT*16-1:0] drv_mask;

    ppio_sync #(.W(NPORT*16)) u_sync
    (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .pin_in(pin_in),
        .pin_stable(pin_sync)
    );

    // Sampled every clock regardless of direction
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            for (int p = 0; p < NPORT; p++)
                in_latch_q[p] <= '0;
        end
        else
        begin
            for (int p = 0; p < NPORT; p++)
                in_latch_q[p] <= pin_sync[p*16 +: 16] & line_mask(p);
        end
    end

    // Map: data, direction and open drain blocks, two bytes per port.
    // Port index 9 to 15 and odd addresses fall outside every block.
    // Address decode: base + kind, port index in bits 4:1
    always_comb
    begin
        sel_port = reg_addr[4:1];
        sel_kind = 2'h0;
        sel_hit = 1'b0;
        if (kind_match(reg_addr, `PPIO_DATA_OFF))
            sel_kind = 2'h1;
        else if (kind_match(reg_addr, `PPIO_DIR_OFF))
            sel_kind = 2'h2;
        else if (kind_match(reg_addr, `PPIO_ODS_OFF))
            sel_kind = 2'h3;
        if (sel_kind != 2'h0 && sel_port < 4'(NPORT))
            sel_hit = 1'b1;
    end

    // Strobe qualifiers, one write per register kind plus port and threshold reads
    always_comb
    begin
        wr_data = reg_wr && sel_hit && sel_kind == 2'h1;
        wr_dir = reg_wr && sel_hit && sel_kind == 2'h2;
        wr_od = reg_wr && sel_hit && sel_kind == 2'h3;
        wr_thr = reg_wr && reg_addr == `PPIO_THR_OFF;
        rd_thr = reg_rd && reg_addr == `PPIO_THR_OFF;
        rd_port = reg_rd && sel_hit;
    end

    // Output latches: plain write or read-modify-write
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            for (int p = 0; p < NPORT; p++)
                out_latch_q[p] <= '0;
        end
        else if (wr_data)
        begin
            for (int p = 0; p < NPORT; p++)
            begin
                if (!has_out(p))
                begin
                    out_latch_q[p] <= '0;
                end
                else if (4'(p) == sel_port)
                begin
                    out_latch_q[p] <= latch_next(reg_op, reg_wdata, p);
                end
            end
        end
    end

    // Direction registers
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            for (int p = 0; p < NPORT; p++)
                dir_q[p] <= '0;
        end
        else if (wr_dir)
        begin
            for (int p = 0; p < NPORT; p++)
                if (4'(p) == sel_port && has_out(p))
                    dir_q[p] <= reg_wdata & line_mask(p);
        end
    end

    // Open-drain registers
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            for (int p = 0; p < NPORT; p++)
                od_q[p] <= '0;
        end
        else if (wr_od)
        begin
            for (int p = 0; p < NPORT; p++)
                if (4'(p) == sel_port && has_od(p))
                    od_q[p] <= reg_wdata & line_mask(p);
        end
    end

    // Threshold selects; no effect on direction or driver paths
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            thr_q <= `PPIO_THR_RST;
        else if (wr_thr)
            thr_q <= reg_wdata & thr_field_mask();
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            threshold_sel_out <= '0;
        else
            threshold_sel_out <= thr_q;
    end

    // Read port: data after the strobe cycle only
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            reg_rdata <= '0;
        else if (rd_thr)
            reg_rdata <= thr_q;
        else if (rd_port)
            reg_rdata <= port_view(sel_kind, dir_q[sel_port],
                out_latch_q[sel_port], in_latch_q[sel_port],
                od_q[sel_port]);
        else
            reg_rdata <= '0;
    end

    always_comb
    begin
        for (int p = 0; p < NPORT; p++)
        begin
            lat_flat[p*16 +: 16] = out_latch_q[p];
            dir_flat[p*16 +: 16] = dir_q[p];
            od_flat[p*16 +: 16] = od_q[p];
            drv_mask[p*16 +: 16] = line_mask(p) & {16{has_out(p)}};
        end
    end

    ppio_pad #(.W(NPORT*16)) u_pad
    (
        .out_latch(lat_flat),
        .dir(dir_flat),
        .open_drain(od_flat),
        .pad_out(pad_o),
        .pad_oe(pad_e)
    );

    // Registered pad drive so outputs come from flip-flops; the mask
    // keeps absent lines quiet even if a register bit were upset
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            pin_out <= '0;
        else
            pin_out <= pad_o & drv_mask;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            pin_oe <= '0;
        else
            pin_oe <= pad_e & drv_mask;
    end
endmodule

// >>> inc/ppio_defines.svh
// Register offsets, reset values and field positions of the parallel ports.
// Included by the package only; the port logic uses its macros; definitions only.
`ifndef PPIO_DEFINES_SVH
`define PPIO_DEFINES_SVH
`define PPIO_ADDR_W 16
`define PPIO_THR_OFF 16'hF1C4
`define PPIO_DATA_OFF 16'hF000
`define PPIO_DIR_OFF 16'hF040
`define PPIO_ODS_OFF 16'hF080
`define PPIO_THR_RST 16'h0000
`define PPIO_THR_MASK 16'h00DF
`define PPIO_P2L_BIT 0
`define PPIO_P2H_BIT 1
`define PPIO_P3L_BIT 2
`define PPIO_P3H_BIT 3
`define PPIO_P4_BIT 4
`define PPIO_P7_BIT 6
`define PPIO_P8_BIT 7
`define PPIO_NPORT 9
`define PPIO_OP_WR 2'h1
`define PPIO_OP_RMW 2'h2
`endif

// >>> inc/ppio_pkg.sv
// Types shared by the parallel port files.
// Assumes ppio_defines.svh is on the include path.
`include "ppio_defines.svh"
package ppio_pkg;
    typedef logic [15:0] ppio_word_t;
    typedef enum logic [1:0]
    {
        PPIO_IDLE = 2'b00,
        PPIO_RMW_WAIT = 2'b01
    } ppio_state_t;
endpackage

// >>> hdl/ppio_sync.sv
// Three-stage pin synchroniser with agreement of stages two and three.
// Assumes asynchronous pin levels; one clock domain.
`timescale 1ns/100ps
module ppio_sync
#(
    parameter int W = 16
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_stable
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            pin_stable <= '0;
        end
        else
        begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // Only a level seen twice counts
            for (int i = 0; i < W; i++)
                if (s2_q[i] == s3_q[i])
                    pin_stable[i] <= s2_q[i];
        end
    end
endmodule

// >>> hdl/ppio_pad.sv
// Per-pin driver control: push-pull or open-drain.
// Assumes the pad resolves enable and data outside.
`timescale 1ns/100ps
module ppio_pad
#(
    parameter int W = 16
)
(
    input wire logic [W-1:0] out_latch,
    input wire logic [W-1:0] dir,
    input wire logic [W-1:0] open_drain,
    output logic [W-1:0] pad_out,
    output logic [W-1:0] pad_oe
);
    always_comb
    begin
        for (int i = 0; i < W; i++)
        begin
            // Open drain only pulls low
            pad_out[i] = open_drain[i] ? 1'b0 : out_latch[i];
            pad_oe[i] = dir[i] & (~open_drain[i] | ~out_latch[i]);
        end
    end
endmodule

// >>> sim/ppio_ports_asserts.sv
// Checker on the parallel port block's register and pin ports.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/100ps
module ppio_ports_asserts
#(
    parameter int NPORT = 9
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [1:0] reg_op,
    input wire logic [15:0] reg_rdata,
    input wire logic [NPORT*16-1:0] pin_in,
    input wire logic [NPORT*16-1:0] pin_out,
    input wire logic [NPORT*16-1:0] pin_oe,
    input wire logic [15:0] threshold_sel_out
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not zero outside a read");
    thr_write_a: assert property (reg_wr && reg_addr == 16'hF1C4
        |=> ##1 threshold_sel_out == ($past(reg_wdata, 2) & 16'h00DF))
        else $error("threshold output does not follow write");
    thr_read_a: assert property (reg_rd && reg_addr == 16'hF1C4
        |=> reg_rdata == threshold_sel_out)
        else $error("threshold read differs from output");
    thr_rsv_a: assert property (threshold_sel_out[15:8] == 8'h00
        && !threshold_sel_out[5])
        else $error("reserved threshold bit set");
    in_only_a: assert property (pin_oe[95:80] == 16'h0000)
        else $error("input-only port drives");
    absent_line_a: assert property (!pin_oe[62])
        else $error("absent port line drives");
    byte_ports_a: assert property (pin_oe[79:72] == 8'h00
        && pin_oe[111:104] == 8'h00 && pin_oe[127:120] == 8'h00
        && pin_oe[143:136] == 8'h00)
        else $error("upper byte of narrow port drives");
    rst_input_a: assert property (disable iff (1'b0)
        sys_rst |=> pin_oe == '0)
        else $error("driver enabled after reset");
    pin_cause_a: assert property ($changed(pin_out) || $changed(pin_oe)
        |-> $past(reg_wr, 2) || $past(sys_rst) || $past(sys_rst, 2))
        else $error("pin drive changed without a write");
    thr_cov: cover property (reg_wr && reg_addr == 16'hF1C4);
    rmw_cov: cover property (reg_wr && reg_op == 2'h2);
    drive_cov: cover property ($rose(pin_oe[32]));
endmodule
bind ppio_ports ppio_ports_asserts #(.NPORT(NPORT)) u_chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_op(reg_op), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe),
    .threshold_sel_out(threshold_sel_out));

// >>> sim/ppio_board.sv
// Board model: pull-ups on every pin plus optional external drivers.
// Assumes a line driven from both sides resolves as wired AND.
`timescale 1ns/100ps
module ppio_board
#(
    parameter int W = 144
)
(
    input wire logic [W-1:0] pin_out,
    input wire logic [W-1:0] pin_oe,
    input wire logic [W-1:0] ext_val,
    input wire logic [W-1:0] ext_en,
    output logic [W-1:0] pin_in
);
    // Released lines go to the pull-up level, never hold the old value
    assign pin_in = (pin_oe & pin_out | ~pin_oe)
        & (ext_en & ext_val | ~ext_en);
endmodule

// >>> sim/tb_ppio_ports.sv
// Self-checking bench for the parallel port block.
// Assumes the board model and the bound checker.
`timescale 1ns/100ps
module tb_ppio_ports import ppio_pkg::*;;
    logic clk_sys = 0;
    logic sys_rst = 1;
    logic [15:0] reg_addr = '0;
    ppio_word_t reg_wdata = '0;
    logic reg_wr = 0;
    logic reg_rd = 0;
    logic [1:0] reg_op = '0;
    ppio_word_t reg_rdata, threshold_sel_out, rv;
    logic [143:0] pin_in, pin_out, pin_oe;
    logic [143:0] ext_val = '0;
    logic [143:0] ext_en = '0;
    int failures = 0;
    int n_compared = 0;
    ppio_ports DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_op(reg_op), .reg_rdata(reg_rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .threshold_sel_out(threshold_sel_out));
    ppio_board u_board (.pin_out(pin_out), .pin_oe(pin_oe),
        .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
    initial
    begin
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input ppio_word_t d,
                      input logic [1:0] op);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_op <= op;
        reg_wr <= 1;
        @(posedge clk_sys);
        reg_wr <= 0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1;
        @(posedge clk_sys);
        reg_rd <= 0;
        #1;
        rv = reg_rdata;
    endtask
    task automatic chk(input string n, input ppio_word_t e,
                       input ppio_word_t g);
        n_compared++;
        if (g !== e)
        begin
            failures++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic rc(input string n, input logic [15:0] a,
                      input ppio_word_t e);
        rd(a);
        chk(n, e, rv);
    endtask
    task automatic wrap_up;
        if (failures == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (3000) @(posedge clk_sys);
        failures++;
        wrap_up;
    end
    initial
    begin
        repeat (3) @(posedge clk_sys);
        sys_rst <= 0;
        ext_en <= {144{1'b1}};
        ext_val[111:32] <= 80'h005A_3C5A_FFFF_FFFF_A5C3;
        wt(6);
        chk("oe_all", 16'h0000, {15'h0, |pin_oe});
        rc("thr", 16'hF1C4, 16'h0000);
        rc("p2in", 16'hF004, 16'hA5C3);
        rc("p3in", 16'hF006, 16'hBFFF);
        rc("p4in", 16'hF008, 16'h00FF);
        rc("p5in", 16'hF00A, 16'h3C5A);
        wr(16'hF1C4, 16'hFFFF, 2'h1);
        rc("thr", 16'hF1C4, 16'h00DF);
        chk("thr_out", 16'h00DF, threshold_sel_out);
        wr(16'hF004, 16'h1234, 2'h1);
        rc("p2w", 16'hF004, 16'hA5C3);
        chk("oe2", 16'h0000, pin_oe[47:32]);
        ext_en[47:32] <= '0;
        wr(16'hF044, 16'hFFFF, 2'h1);
        wt(3);
        chk("pin2", 16'h1234, pin_out[47:32]);
        chk("oe2", 16'hFFFF, pin_oe[47:32]);
        rc("p2o", 16'hF004, 16'h1234);
        wr(16'hF004, rv | 16'h0F00, 2'h2);
        wt(3);
        chk("pin2", 16'h1F34, pin_out[47:32]);
        rc("p6in", 16'hF00C, 16'h005A);
        wr(16'hF00C, rv ^ 16'h00FF, 2'h2);
        ext_en[111:96] <= '0;
        wr(16'hF04C, 16'h00FF, 2'h1);
        wt(3);
        chk("pin6", 16'h00A5, pin_out[111:96]);
        // Open drain: only low latch bits may enable the driver
        ext_en[127:112] <= '0;
        wr(16'hF08E, 16'h00FF, 2'h1);
        wr(16'hF04E, 16'h00FF, 2'h1);
        wr(16'hF00E, 16'h000F, 2'h1);
        wt(3);
        chk("oe7", 16'h00F0, pin_oe[127:112]);
        chk("pin7", 16'h0000, pin_out[127:112]);
        ext_en[15:0] <= '0;
        wr(16'hF080, 16'hFFFF, 2'h1);
        wr(16'hF040, 16'hFFFF, 2'h1);
        wr(16'hF000, 16'h00FF, 2'h1);
        wt(3);
        chk("pin0", 16'h00FF, pin_out[15:0]);
        chk("oe0", 16'hFFFF, pin_oe[15:0]);
        wr(16'hF04A, 16'hFFFF, 2'h1);
        wr(16'hF00A, 16'hFFFF, 2'h1);
        wt(3);
        chk("oe5", 16'h0000, pin_oe[95:80]);
        rc("none", 16'hF200, 16'h0000);
        wrap_up;
    end
endmodule
